/* i2c_port_pkg.sv */
package i2c_port_pkg;

    // fsm of the byte engine
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WRX,
        ST_TX,
        ST_TX_ACK
    } port_state_t;

    // clock and spike timing, derived counts round up
    localparam int CLK_NS = 50;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] FILT_CYC = 4'(SPIKE_CYC + 1);

    // bus rates; fast-mode half period is many cycles longer than the filter delay
    localparam int SCL_STD_KHZ = 100;
    localparam int SCL_FAST_KHZ = 400;
    localparam int FAST_HALF_CYC = (1000000 / SCL_FAST_KHZ / 2) / CLK_NS;

    // byte framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;

    // strap capture: settle cycles after reset release
    localparam logic [1:0] STRAP_DONE = 2'h3;

    // slave address base, low two bits from the strap; value is arbitrary
    localparam logic [6:0] SLV_BASE = 7'h2c;

    // write queue shape
    localparam int FIFO_DEPTH = 32;
    localparam int WR_W = 24;

    // reset values of the filtered lines (released bus reads high) and of the register pointer
    localparam logic [1:0] LINE_IDLE = 2'h3;
    localparam logic [15:0] PTR_RST = 16'h0000;

endpackage

/* wq_if.sv */
`timescale 1ns/1ps
// write stream between the byte engine and its queue
interface wq_if #(parameter int W = 24);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport ctl (output in_valid, output in_data, output out_ready,
                 input in_ready, input out_valid, input out_data);
    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
endinterface

/* stream_fifo.sv */
`timescale 1ns/1ps
module stream_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    wq_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_P = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic ov;
        logic [W-1:0] od;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t n;
    logic [W-1:0] mem [DEPTH];
    logic full;
    logic wr;
    logic load;

    // full counts only the array; the output register holds one extra word
    assign full = (s.wp - s.rp) == DEPTH_P;
    assign wr = f.in_valid && !full;
    assign load = (s.wp != s.rp) && (!s.ov || f.out_ready);
    assign f.in_ready = !full;
    assign f.out_valid = s.ov;
    assign f.out_data = s.od;

    // pointer and output stage update
    always_comb begin
        n = s;
        if (wr) begin
            n.wp = s.wp + 1'b1;
        end
        if (load) begin
            n.ov = 1'b1;
            n.od = mem[s.rp[AW-1:0]];
            n.rp = s.rp + 1'b1;
        end else if (f.out_ready) begin
            n.ov = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge clk) begin
        if (wr) begin
            mem[s.wp[AW-1:0]] <= f.in_data;
        end
    end

    AST_FIFO_NO_OVERRUN: assert property (@(posedge clk) disable iff (!reset_n)
        (f.in_valid && full) |=> (s.wp == $past(s.wp)))
        else $error("fifo accepted a word while full");

endmodule // stream_fifo

/* i2c_slave_register_port.sv */
`timescale 1ns/1ps
module i2c_slave_register_port (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [1:0] addr_sel,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_req,
    output logic [15:0] rd_addr,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);
    import i2c_port_pkg::*;

    // index 0 is the clock line, index 1 the data line
    typedef struct packed {
        logic [1:0] ln_s1;
        logic [1:0] ln_s2;
        logic [1:0] ln_f;
        logic [1:0] ln_p;
        logic [1:0][3:0] ln_cnt;
        logic [1:0] sel_s1;
        logic [1:0] sel_s2;
        logic [1:0] strap_cnt;
        logic [6:0] own_addr;
        port_state_t state;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic [7:0] txb;
        logic rw;
        logic [1:0] idx;
        logic [7:0] addr_hi;
        logic [15:0] ptr;
        logic sda_oe;
        logic sda_o;
        logic push;
        logic [15:0] in_addr;
        logic [7:0] in_data;
        logic rd_req;
        logic [15:0] rd_addr;
        logic mack_n;
    } port_reg_t;

    port_reg_t s;
    port_reg_t n;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic addr_hit;

    wq_if #(.W(WR_W)) wq ();

    // write queue: a full queue makes the engine nack data bytes
    stream_fifo #(.W(WR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .f(wq.fifo)
    );

    assign wq.in_valid = s.push;
    assign wq.in_data = {s.in_addr, s.in_data};
    assign wq.out_ready = wr_ready;
    assign wr_valid = wq.out_valid;
    assign wr_addr = wq.out_data[23:8];
    assign wr_data = wq.out_data[7:0];

    // pin outputs; only the data line has a driver at all
    assign sda_o = s.sda_o;
    assign sda_oe = s.sda_oe;
    assign rd_req = s.rd_req;
    assign rd_addr = s.rd_addr;

    // bus events from the filtered lines, valid for one cycle
    assign scl_rise = s.ln_f[0] && !s.ln_p[0];
    assign scl_fall = !s.ln_f[0] && s.ln_p[0];
    assign start_c = s.ln_f[0] && s.ln_p[0] && s.ln_p[1] && !s.ln_f[1];
    assign stop_c = s.ln_f[0] && s.ln_p[0] && !s.ln_p[1] && s.ln_f[1];
    assign addr_hit = (s.sh[7:1] == s.own_addr) && (s.strap_cnt == STRAP_DONE);

    // next-state logic for the whole port
    always_comb begin
        n = s;
        n.push = 1'b0;
        n.rd_req = 1'b0;
        n.sda_o = 1'b0;

        // two-stage synchronisers for the pins
        n.ln_s1 = {sda_i, scl_i};
        n.ln_s2 = s.ln_s1;
        n.sel_s1 = addr_sel;
        n.sel_s2 = s.sel_s1;
        n.ln_p = s.ln_f;

        // spike filter: a new level must be seen on consecutive samples
        for (int i = 0; i < 2; i++) begin
            if (s.ln_s2[i] != s.ln_f[i]) begin
                n.ln_cnt[i] = s.ln_cnt[i] + 4'h1;
                if (n.ln_cnt[i] == FILT_CYC) begin
                    n.ln_f[i] = s.ln_s2[i];
                    n.ln_cnt[i] = 4'h0;
                end
            end else begin
                n.ln_cnt[i] = 4'h0;
            end
        end

        // strap is taken a few cycles after release, then frozen
        if (s.strap_cnt != STRAP_DONE) begin
            n.strap_cnt = s.strap_cnt + 2'h1;
            n.own_addr = {SLV_BASE[6:2], s.sel_s2};
        end

        // read data from the register side lands in the transmit buffer
        if (rd_valid) begin
            n.txb = rd_data;
        end

        if (start_c) begin
            // a start overrides any state and drops a partial byte
            n.state = ST_ADDR;
            n.bit_cnt = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.state = ST_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (s.state)
                ST_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                ST_ADDR, ST_WRX: begin
                    // shift in on the rising edge, msb first
                    if (scl_rise && s.bit_cnt != BITS_PER_BYTE) begin
                        n.sh = {s.sh[6:0], s.ln_f[1]};
                        n.bit_cnt = s.bit_cnt + 4'h1;
                    end
                    if (scl_fall && s.bit_cnt == BITS_PER_BYTE) begin
                        n.bit_cnt = 4'h0;
                        if (s.state == ST_ADDR) begin
                            if (addr_hit) begin
                                n.state = ST_ACK;
                                n.sda_oe = 1'b1;
                                n.rw = s.sh[0];
                                n.idx = 2'h0;
                                if (s.sh[0]) begin
                                    // fetch the first byte during the ack slot
                                    n.rd_req = 1'b1;
                                    n.rd_addr = s.ptr;
                                end
                            end else begin
                                n.state = ST_IDLE;
                            end
                        end else begin
                            n.state = ST_ACK;
                            case (s.idx)
                                2'h0: begin
                                    n.addr_hi = s.sh;
                                    n.idx = 2'h1;
                                    n.sda_oe = 1'b1;
                                end
                                2'h1: begin
                                    // pointer loads even if no data follows
                                    n.ptr = {s.addr_hi, s.sh};
                                    n.idx = 2'h2;
                                    n.sda_oe = 1'b1;
                                end
                                default: begin
                                    if (wq.in_ready) begin
                                        n.push = 1'b1;
                                        n.in_addr = s.ptr;
                                        n.in_data = s.sh;
                                        n.ptr = s.ptr + 16'h0001;
                                        n.sda_oe = 1'b1;
                                    end else begin
                                        n.sda_oe = 1'b0;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    // ack slot ends on the falling edge of the ninth pulse
                    if (scl_fall) begin
                        if (s.rw) begin
                            n.state = ST_TX;
                            n.sda_oe = !s.txb[7];
                            n.sh = {s.txb[6:0], 1'b0};
                            n.bit_cnt = BIT_FIRST;
                        end else begin
                            n.state = ST_WRX;
                            n.sda_oe = 1'b0;
                            n.bit_cnt = 4'h0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (s.bit_cnt == BITS_PER_BYTE) begin
                            // release for the master's ack, prefetch the next byte
                            n.state = ST_TX_ACK;
                            n.sda_oe = 1'b0;
                            n.bit_cnt = 4'h0;
                            n.ptr = s.ptr + 16'h0001;
                            n.rd_req = 1'b1;
                            n.rd_addr = s.ptr + 16'h0001;
                        end else begin
                            n.sda_oe = !s.sh[7];
                            n.sh = {s.sh[6:0], 1'b0};
                            n.bit_cnt = s.bit_cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        n.mack_n = s.ln_f[1];
                    end
                    if (scl_fall) begin
                        if (s.mack_n) begin
                            // master closes the read; it makes the stop itself
                            n.state = ST_IDLE;
                            n.sda_oe = 1'b0;
                        end else begin
                            n.state = ST_TX;
                            n.sda_oe = !s.txb[7];
                            n.sh = {s.txb[6:0], 1'b0};
                            n.bit_cnt = BIT_FIRST;
                        end
                    end
                end
                default: begin
                    n.state = ST_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // single state register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
            // synchronisers start at the released level, else a false rise follows reset
            s.ln_s1 <= LINE_IDLE;
            s.ln_s2 <= LINE_IDLE;
            s.ln_f <= LINE_IDLE;
            s.ln_p <= LINE_IDLE;
            s.ptr <= PTR_RST;
        end else begin
            s <= n;
        end
    end

    AST_SPIKE_REJECT: assert property (@(posedge clk) disable iff (!reset_n)
        (s.ln_f[0] != $past(s.ln_f[0]))
        |-> ($past(s.ln_s2[0]) == s.ln_f[0]) && ($past(s.ln_s2[0], 2) == s.ln_f[0]))
        else $error("clock filter passed a single-sample pulse");

    AST_DRIVE_CLOCK_LOW: assert property (@(posedge clk) disable iff (!reset_n)
        ($changed(s.sda_oe) && s.state != ST_IDLE && s.state != ST_ADDR)
        |-> !s.ln_f[0])
        else $error("data drive changed while clock high");

    AST_ACK_AFTER_MATCH: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_ACK && $past(s.state) == ST_ADDR) |-> (s.sda_oe && !s.sda_o))
        else $error("matched address not acknowledged");

    AST_NO_MATCH_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_ADDR && scl_fall && !start_c && !stop_c
         && s.bit_cnt == BITS_PER_BYTE && !addr_hit)
        |=> (s.state == ST_IDLE && !s.sda_oe))
        else $error("foreign address not ignored");

    AST_START_RESTART: assert property (@(posedge clk) disable iff (!reset_n)
        start_c |=> (s.state == ST_ADDR && s.bit_cnt == 4'h0 && !s.sda_oe))
        else $error("start did not restart address capture");

    AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        (stop_c && !start_c) |=> (s.state == ST_IDLE && !s.sda_oe))
        else $error("stop did not return to idle");

    AST_PTR_AFTER_PUSH: assert property (@(posedge clk) disable iff (!reset_n)
        s.push |-> (s.ptr == s.in_addr + 16'h0001))
        else $error("pointer not advanced after a written byte");

    AST_PTR_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_WRX && scl_fall && !start_c && !stop_c
         && s.bit_cnt == BITS_PER_BYTE && s.idx == 2'h1)
        |=> (s.ptr == {$past(s.addr_hi), $past(s.sh)} && !s.push))
        else $error("register address not loaded high byte first");

    AST_NACK_ENDS_READ: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_TX_ACK && scl_fall && s.mack_n && !start_c && !stop_c)
        |=> (s.state == ST_IDLE && !s.sda_oe) [*2])
        else $error("read not ended on master nack");

    AST_IDLE_RELEASED: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_IDLE) |-> !s.sda_oe)
        else $error("data line pulled while idle");

    AST_BYTE_BOUND: assert property (@(posedge clk) disable iff (!reset_n)
        s.bit_cnt <= BITS_PER_BYTE)
        else $error("bit counter ran past one byte");

    AST_REGADDR_ACK: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_WRX && scl_fall && !start_c && !stop_c
         && s.bit_cnt == BITS_PER_BYTE && s.idx != 2'h2)
        |=> (s.state == ST_ACK && s.sda_oe))
        else $error("register address byte not acknowledged");

    AST_FULL_NACK: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_WRX && scl_fall && !start_c && !stop_c
         && s.bit_cnt == BITS_PER_BYTE && s.idx == 2'h2 && !wq.in_ready)
        |=> (s.state == ST_ACK && !s.sda_oe && !s.push))
        else $error("data byte taken while queue full");

    AST_READ_FETCH: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_ADDR && scl_fall && !start_c && !stop_c
         && s.bit_cnt == BITS_PER_BYTE && addr_hit && s.sh[0])
        |=> (s.rd_req && s.rd_addr == $past(s.ptr)))
        else $error("read did not fetch from the current pointer");

    AST_TX_PREFETCH: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_TX && scl_fall && !start_c && !stop_c && s.bit_cnt == BITS_PER_BYTE)
        |=> (s.rd_req && s.ptr == $past(s.ptr) + 16'h0001 && s.rd_addr == s.ptr))
        else $error("pointer not advanced after a sent byte");

    AST_RD_REQ_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
        s.rd_req |=> !s.rd_req)
        else $error("fetch requests back to back");

    AST_TX_MSB_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_ACK && scl_fall && s.rw && !start_c && !stop_c)
        |=> (s.state == ST_TX && s.sda_oe == !$past(s.txb[7])))
        else $error("first sent bit is not the msb");

    AST_ACK_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        (s.state == ST_ACK && !scl_fall && !start_c && !stop_c)
        |=> $stable(s.sda_oe))
        else $error("acknowledge drive moved inside the slot");

endmodule // i2c_slave_register_port

/* bus_master.sv */
`timescale 1ns/1ps
// bus master on the far side of the port; it alone owns the clock line
module bus_master (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_oe
);
    int half = 25; // clock half period in system cycles
    int glitch = 0; // 1 adds one-cycle spikes to every sent bit

    // released bus at time zero
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // every pin move lands on a falling system edge, away from sampling
    task automatic wait_q(input int n);
        repeat (n) @(negedge clk);
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_oe = 1'b0;
        wait_q(half / 2);
        scl = 1'b1;
        wait_q(half);
        sda_oe = 1'b1;
        wait_q(half);
        scl = 1'b0;
        wait_q(half / 2);
    endtask

    // data pulled low in the low phase, then released while clock is high
    task automatic stop();
        sda_oe = 1'b1;
        wait_q(half / 2);
        scl = 1'b1;
        wait_q(half);
        sda_oe = 1'b0;
        wait_q(half);
    endtask

    // data moves while the clock is low, except the data spike in the high phase; spikes stay one cycle wide
    task automatic send_bit(input logic b);
        sda_oe = ~b;
        wait_q(half / 2);
        scl = 1'b1;
        wait_q(half / 2);
        if (glitch != 0) begin
            sda_oe = b;
            wait_q(1);
            sda_oe = ~b;
        end
        wait_q(half / 2 - glitch);
        scl = 1'b0;
        wait_q(half / 4);
        if (glitch != 0) begin
            scl = 1'b1;
            wait_q(1);
            scl = 1'b0;
        end
        wait_q(half / 2 - half / 4 - glitch);
    endtask

    // line sampled in the middle of the high phase
    task automatic get_bit(output logic b);
        sda_oe = 1'b0;
        wait_q(half / 2);
        scl = 1'b1;
        wait_q(half / 2);
        b = sda_in;
        wait_q(half / 2);
        scl = 1'b0;
        wait_q(half / 2);
    endtask

    // eight bits msb first, then the slave answers in the ninth slot
    task automatic write_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) send_bit(d[i]);
        get_bit(ack);
        ack = ~ack;
    endtask

    // as receiver the master pulls low to accept, leaves high on the last
    task automatic read_byte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        send_bit(~ack);
    endtask
endmodule // bus_master

/* tb_i2c_slave_register_port.sv */
`timescale 1ns/1ps
module tb_i2c_slave_register_port;
    import i2c_port_pkg::*;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] addr_sel = 2'h0;
    logic wr_ready = 1'b0;
    logic rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic sda_o, sda_oe, wr_valid, rd_req, scl, m_oe, sda_line, oe_prev, stall;
    logic [15:0] wr_addr, rd_addr, ref_ptr;
    logic [7:0] wr_data;
    logic [31:0] seed = 32'h0000_004a;
    logic [31:0] tmp;
    logic [6:0] own;
    logic [23:0] exp_wq [$];
    logic [7:0] ref_mem [int];
    logic [7:0] dev_mem [int];
    int bad_count = 0;
    int n_checks = 0;
    int rd_wait = 0;
    int hc = 0;

    always #25 clk = ~clk;
    // open-drain wire with pull-up: low while either side pulls
    assign sda_line = ~(m_oe | sda_oe);

    i2c_slave_register_port i2c_slave_register_port_i (.clk(clk), .reset_n(reset_n),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
    bus_master bus_master_i (.clk(clk), .sda_in(sda_line), .scl(scl), .sda_oe(m_oe));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // contents of a register nobody has written
    function automatic logic [7:0] seed_val(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    function automatic logic [7:0] ref_rd(input logic [15:0] a);
        return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : seed_val(a);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // register side: random fetch latency, random stalls of the write consumer
    always @(negedge clk) begin
        rd_valid = 1'b0;
        tmp = rnd();
        if (reset_n && rd_req === 1'b1) begin
            rd_wait = 1 + int'(tmp[2:0]);
        end else if (rd_wait > 0) begin
            rd_wait--;
            if (rd_wait == 0) begin
                rd_valid = 1'b1;
                rd_data = dev_mem.exists(int'(rd_addr)) ? dev_mem[int'(rd_addr)] : seed_val(rd_addr);
            end
        end
        wr_ready = ~stall & tmp[9];
        // the slave must hold its drive through the clock-high phase
        hc = (scl === 1'b1) ? hc + 1 : 0;
        if (hc > 8 && sda_oe !== oe_prev) check({31'h0, sda_oe}, {31'h0, oe_prev});
        oe_prev = sda_oe;
    end

    // every word taken must be the next one the reference expects
    always @(posedge clk) begin
        if (reset_n && wr_valid === 1'b1 && wr_ready) begin
            if (exp_wq.size() == 0) begin
                check({8'h00, wr_addr, wr_data}, 32'hffff_ffff);
            end else begin
                check({8'h00, wr_addr, wr_data}, {8'h00, exp_wq.pop_front()});
            end
            dev_mem[int'(wr_addr)] = wr_data;
        end
    end

    task automatic do_reset(input logic [1:0] sel);
        reset_n = 1'b0;
        addr_sel = sel;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (12) @(negedge clk);
        addr_sel = ~sel; // strap is frozen by now
        own = {SLV_BASE[6:2], sel};
        ref_ptr = PTR_RST;
        check({30'h0, sda_o, sda_oe}, 32'h0);
    endtask

    // slave address byte: seven address bits then the direction bit
    task automatic send_addr(input logic [6:0] a, input logic rd, input logic exp_ack);
        logic ack;
        bus_master_i.start();
        bus_master_i.write_byte({a, rd}, ack);
        check({31'h0, ack}, {31'h0, exp_ack});
    endtask

    // write: pointer high byte, low byte, then n data bytes
    task automatic wr_xfer(input logic [15:0] a, input int n, output int nacks);
        logic ack;
        logic [7:0] d;
        nacks = 0;
        send_addr(own, 1'b0, 1'b1);
        bus_master_i.write_byte(a[15:8], ack);
        check({31'h0, ack}, 32'h1);
        bus_master_i.write_byte(a[7:0], ack);
        check({31'h0, ack}, 32'h1);
        ref_ptr = a;
        for (int i = 0; i < n; i++) begin
            tmp = rnd();
            d = tmp[7:0];
            // queued early: the word can leave the queue before the ack slot ends
            exp_wq.push_back({ref_ptr, d});
            bus_master_i.write_byte(d, ack);
            if (ack === 1'b1) begin
                ref_mem[int'(ref_ptr)] = d;
                ref_ptr++;
            end else begin
                void'(exp_wq.pop_back());
                nacks++;
            end
        end
    endtask

    // read from the current pointer; the master refuses the last byte
    task automatic rd_xfer(input int n);
        logic [7:0] d;
        send_addr(own, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            bus_master_i.read_byte(i != n - 1, d);
            check({24'h0, d}, {24'h0, ref_rd(ref_ptr)});
            ref_ptr++;
        end
        bus_master_i.stop();
    endtask

    task automatic drain();
        for (int k = 0; k < 4000 && exp_wq.size() != 0; k++) @(negedge clk);
        check(32'(exp_wq.size()), 32'h0);
        if (exp_wq.size() != 0) finish_test();
    endtask

    // a hang ends the run as a failure
    initial begin
        repeat (95000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    initial begin
        int nk;
        stall = 1'b0;
        oe_prev = 1'b0;
        // each strap value answers its own address only
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            send_addr(own ^ 7'h01, 1'b0, 1'b0);
            bus_master_i.stop();
            wr_xfer(16'h0100 + 16'(s), 0, nk);
            bus_master_i.stop();
            rd_xfer(2);
        end
        $display("test strap done");
        // both rates, burst across a carry, spikes at the fast rate
        for (int j = 0; j < 2; j++) begin
            bus_master_i.half = (j == 0) ? FAST_HALF_CYC * SCL_FAST_KHZ / SCL_STD_KHZ
                                         : FAST_HALF_CYC;
            bus_master_i.glitch = j;
            wr_xfer(16'h12fe, 4, nk);
            bus_master_i.stop();
            check(32'(nk), 32'h0);
            bus_master_i.glitch = 0;
            drain();
            wr_xfer(16'h12fd, 0, nk);
            rd_xfer(5);
            rd_xfer(1);
        end
        $display("test rates done");
        // start and stop arriving mid-byte drop the partial byte
        wr_xfer(16'h0040, 1, nk);
        for (int b = 0; b < 3; b++) bus_master_i.send_bit(1'b1);
        wr_xfer(16'h0050, 1, nk);
        bus_master_i.send_bit(1'b0);
        bus_master_i.stop();
        drain();
        rd_xfer(1);
        $display("test restart done");
        // stalled consumer: queue fills, surplus refused, pointer held
        stall = 1'b1;
        wr_xfer(16'h2000, 36, nk);
        bus_master_i.stop();
        check(32'(nk != 0 && 36 - nk >= FIFO_DEPTH), 32'h1);
        stall = 1'b0;
        drain();
        rd_xfer(2);
        $display("test full done");
        finish_test();
    end
endmodule // tb_i2c_slave_register_port
